/* logic/scd_dispatch.sv */
// Supervisory call dispatcher: decodes the call opcode, checks the guard
// keys in the page 0 parameter block and starts one flash routine.
// Assumes a core that stalls on busy_o and a flash engine with start/done.
// Summary of operation
// - Opcode 00h enters supervisory ROM space instead of executing as ordinary code.
// - Codes 00h,01h,02h,03h,05h,06h,07h select routines; each needs its stack space.
// - An undefined function code from user code halts the processor.
// - Second guard key must equal stack pointer at call plus three.
// - Any guard key mismatch halts, except for the boot reset function.
// - Parameter block sits at page 0 addresses F8h to FFh.
// - Flash control registers are visible only while running supervisory ROM.
// - Four auxiliary rows exist; full erase leaves them untouched.
// - External programmer reaches the same functions in serial programming mode.
// - Return code in first key location: 00h ok, 01h protected, 02h software reset, 03h fatal; the code never writes 02h.
// - Hardware reset clears accumulator and runs boot reset with calibration checksum.
`timescale 1ns/1ps
module scd_dispatch
  import scd_pkg::*;
(
  input wire logic clk_i, // 20 MHz clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic op_valid_i, // Fetched opcode is valid
  input wire logic [7:0] opcode_i, // Fetched opcode
  input wire logic [7:0] acc_i, // Accumulator value
  input wire logic [7:0] sp_i, // Stack pointer value
  input wire logic [15:0] pc_i, // Address of the fetched opcode
  input wire logic serial_mode_i, // External programmer mode
  input wire logic serial_req_i, // Test queue request pulse
  input wire logic [7:0] serial_fn_i, // Test queue function code
  output logic sram_rd_o, // Parameter block read strobe
  output logic sram_wr_o, // Parameter block write strobe
  output logic [7:0] sram_addr_o, // Parameter block address
  output logic [7:0] sram_wdata_o, // Parameter block write data
  input wire logic [7:0] sram_rdata_i, // Data for previous read
  output logic flash_start_o, // Start routine pulse
  output logic [7:0] flash_fn_o, // Routine function code
  output logic flash_keep_aux_o, // Protect auxiliary rows
  input wire logic flash_done_i, // Routine finished pulse
  input wire logic flash_denied_i, // Block protection refused
  input wire logic flash_fatal_i, // Fatal error in routine
  input wire logic cal_ok_i, // Calibration checksum good
  input wire logic flash_has_rc_i, // Routine leaves a return code
  output logic busy_o, // Core must stall
  output logic sup_mode_o, // Flash control registers visible
  output logic acc_clear_o, // Clear accumulator pulse
  output logic halt_o, // Processor halted
  output logic resume_o, // Resume pulse
  output logic [15:0] resume_pc_o // Resume address
);
  scd_state_t state_reg;
  scd_state_t state_next;
  logic [7:0] fn_reg;
  logic [7:0] fn_next;
  logic [7:0] sp_reg;
  logic [7:0] sp_next;
  logic [15:0] pc_reg;
  logic [15:0] pc_next;
  logic ext_reg;
  logic ext_next;
  logic halt_reg;
  logic halt_next;
  logic boot_reg;
  logic boot_next;

  logic defined_fn;
  logic [7:0] req_fn;
  logic call_req;
  logic [7:0] rc_code;

  always_comb begin
    case (fn_reg)
      SCD_FN_BOOT: defined_fn = 1'b1;
      SCD_FN_READ: defined_fn = 1'b1;
      SCD_FN_WRITE: defined_fn = 1'b1;
      SCD_FN_ERASE: defined_fn = 1'b1;
      SCD_FN_ERASE_ALL: defined_fn = 1'b1;
      SCD_FN_TABLE: defined_fn = 1'b1;
      SCD_FN_CHECKSUM: defined_fn = 1'b1;
      default: defined_fn = 1'b0;
    endcase
  end

  // Return code chosen from the routine's outcome
  always_comb begin
    if (flash_denied_i) begin
      rc_code = SCD_RC_PROTECT;
    end else begin
      rc_code = SCD_RC_OK;
    end
  end

  // Serial test queue takes the place of the core's call
  assign call_req = serial_mode_i ? serial_req_i
                                  : (op_valid_i && opcode_i == SCD_OP_CALL);
  assign req_fn = serial_mode_i ? serial_fn_i : acc_i;

  always_comb begin
    state_next = state_reg;
    fn_next = fn_reg;
    sp_next = sp_reg;
    pc_next = pc_reg;
    ext_next = ext_reg;
    halt_next = halt_reg;
    boot_next = boot_reg;
    sram_rd_o = 1'b0;
    sram_wr_o = 1'b0;
    sram_addr_o = SCD_PB_FIRST_GUARD_KEY;
    sram_wdata_o = SCD_RC_OK;
    resume_o = 1'b0;
    case (state_reg)
      SCD_IDLE: begin
        if (boot_reg) begin
          // Reset entry: accumulator cleared, boot routine runs
          fn_next = SCD_FN_BOOT;
          boot_next = 1'b0;
          ext_next = 1'b0;
          state_next = SCD_RUN;
        end else if (call_req && !halt_reg) begin
          fn_next = req_fn;
          sp_next = sp_i;
          pc_next = pc_i + 16'h0001;
          ext_next = serial_mode_i;
          state_next = SCD_FIRST_GUARD_KEY;
          sram_rd_o = 1'b1;
          sram_addr_o = SCD_PB_FIRST_GUARD_KEY;
        end
      end
      SCD_FIRST_GUARD_KEY: begin
        sram_rd_o = 1'b1;
        sram_addr_o = SCD_PB_SECOND_GUARD_KEY;
        // Undefined code halts before the keys matter
        if (!defined_fn) begin
          state_next = SCD_HALT;
        end else if (fn_reg == SCD_FN_BOOT) begin
          state_next = SCD_RUN;
        end else if (sram_rdata_i != SCD_FIRST_GUARD_KEY_VALUE) begin
          state_next = SCD_HALT;
        end else begin
          state_next = SCD_SECOND_GUARD_KEY;
        end
      end
      SCD_SECOND_GUARD_KEY: begin
        if (sram_rdata_i != sp_reg + SCD_SECOND_GUARD_KEY_OFFSET) begin
          state_next = SCD_HALT;
        end else begin
          state_next = SCD_RUN;
        end
      end
      SCD_RUN: begin
        // Wait for the routine's done pulse
        if (flash_done_i) begin
          if (flash_fatal_i || (fn_reg == SCD_FN_BOOT && !cal_ok_i)) begin
            state_next = SCD_HALT;
          end else begin
            state_next = SCD_RESULT;
          end
        end
      end
      SCD_RESULT: begin
        // Table read and checksum reuse the key slot for data
        sram_wr_o = flash_has_rc_i && fn_reg != SCD_FN_BOOT;
        sram_addr_o = SCD_PB_FIRST_GUARD_KEY;
        sram_wdata_o = rc_code;
        resume_o = 1'b1;
        state_next = SCD_IDLE;
      end
      SCD_HALT: begin
        sram_wr_o = 1'b1;
        sram_addr_o = SCD_PB_FIRST_GUARD_KEY;
        sram_wdata_o = SCD_RC_FATAL;
        // Sticky until the next reset
        halt_next = 1'b1;
        state_next = SCD_IDLE;
      end
      default: state_next = SCD_IDLE;
    endcase
  end

  // Start pulse issued on entry to the run state
  logic run_entered_reg;
  logic run_entered_next;
  always_comb begin
    run_entered_next = (state_reg != SCD_RUN) && (state_next == SCD_RUN);
  end

  // State registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= SCD_IDLE;
      fn_reg <= SCD_FN_BOOT;
      sp_reg <= 8'h00;
      pc_reg <= 16'h0000;
      ext_reg <= 1'b0;
      halt_reg <= 1'b0;
      boot_reg <= 1'b1;
      run_entered_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      fn_reg <= fn_next;
      sp_reg <= sp_next;
      pc_reg <= pc_next;
      ext_reg <= ext_next;
      halt_reg <= halt_next;
      boot_reg <= boot_next;
      run_entered_reg <= run_entered_next;
    end
  end

  // Outputs toward the core and the flash engine
  assign flash_start_o = run_entered_reg;
  assign flash_fn_o = fn_reg;
  assign flash_keep_aux_o = 1'b1;
  assign busy_o = (state_reg != SCD_IDLE) || boot_reg;
  assign sup_mode_o = busy_o;
  assign acc_clear_o = boot_reg;
  assign halt_o = halt_reg;
  assign resume_pc_o = pc_reg;
endmodule

/* logic/scd_pkg.sv */
// Package for the supervisory call dispatcher: opcodes, function codes,
// parameter block addresses, guard key constants and return codes.
// Assumes an 8-bit core with a 256-byte page 0 SRAM.
package scd_pkg;
  localparam logic [7:0] SCD_OP_CALL = 8'h00;
  localparam logic [7:0] SCD_FN_BOOT = 8'h00;
  localparam logic [7:0] SCD_FN_READ = 8'h01;
  localparam logic [7:0] SCD_FN_WRITE = 8'h02;
  localparam logic [7:0] SCD_FN_ERASE = 8'h03;
  localparam logic [7:0] SCD_FN_ERASE_ALL = 8'h05;
  localparam logic [7:0] SCD_FN_TABLE = 8'h06;
  localparam logic [7:0] SCD_FN_CHECKSUM = 8'h07;
  localparam logic [7:0] SCD_FIRST_GUARD_KEY_VALUE = 8'h3A;
  localparam logic [7:0] SCD_SECOND_GUARD_KEY_OFFSET = 8'h03;
  localparam logic [7:0] SCD_PB_FIRST_GUARD_KEY = 8'hF8;
  localparam logic [7:0] SCD_PB_SECOND_GUARD_KEY = 8'hF9;
  localparam logic [7:0] SCD_PB_BLOCK = 8'hFA;
  localparam logic [7:0] SCD_PB_POINTER = 8'hFB;
  localparam logic [7:0] SCD_PB_CLOCK = 8'hFC;
  localparam logic [7:0] SCD_PB_MODE = 8'hFD;
  localparam logic [7:0] SCD_PB_DELAY = 8'hFE;
  localparam logic [7:0] SCD_PB_PCL = 8'hFF;
  localparam logic [7:0] SCD_RC_OK = 8'h00;
  localparam logic [7:0] SCD_RC_PROTECT = 8'h01;
  localparam logic [7:0] SCD_RC_SWRESET = 8'h02;
  localparam logic [7:0] SCD_RC_FATAL = 8'h03;
  localparam logic [7:0] SCD_STACK_BOOT = 8'h00;
  localparam logic [7:0] SCD_STACK_READ = 8'h07;
  localparam logic [7:0] SCD_STACK_WRITE = 8'h0A;
  localparam logic [7:0] SCD_STACK_ERASE = 8'h09;
  localparam logic [7:0] SCD_STACK_ERASE_ALL = 8'h0B;
  localparam logic [7:0] SCD_STACK_SMALL = 8'h03;

  typedef enum logic [2:0] {
    SCD_IDLE = 3'b000,
    SCD_FIRST_GUARD_KEY = 3'b001,
    SCD_SECOND_GUARD_KEY = 3'b011,
    SCD_RUN = 3'b010,
    SCD_RESULT = 3'b110,
    SCD_HALT = 3'b111
  } scd_state_t;
endpackage

/* verification/scd_monitor.sv */
// Checker on the dispatcher ports.
// Bound onto scd_dispatch below.
`timescale 1ns/1ps
module scd_monitor
  import scd_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic op_valid_i, // Fetch valid
  input wire logic [7:0] opcode_i, // Opcode
  input wire logic busy_o, // Busy
  input wire logic halt_o, // Halted
  input wire logic sup_mode_o, // Sup mode
  input wire logic flash_start_o, // Start
  input wire logic [7:0] flash_fn_o, // Function
  input wire logic flash_keep_aux_o, // Aux kept
  input wire logic resume_o, // Resume
  input wire logic sram_rd_o, // Read
  input wire logic sram_wr_o, // Write
  input wire logic [7:0] sram_addr_o, // Address
  input wire logic [7:0] sram_wdata_o // Write data
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_call;
    op_valid_i && opcode_i == SCD_OP_CALL && !busy_o && !halt_o;
  endsequence
  sequence s_fatal;
    sram_wr_o && sram_wdata_o == SCD_RC_FATAL;
  endsequence
  property p_enter; s_call |=> busy_o; endproperty
  a_enter: assert property (p_enter) else $error("call not entered");
  property p_sticky; halt_o |=> halt_o; endproperty
  a_sticky: assert property (p_sticky) else $error("halt released");
  property p_hide; !busy_o |-> !sup_mode_o; endproperty
  a_hide: assert property (p_hide) else $error("sup mode in user code");
  property p_leave; resume_o |=> !sup_mode_o; endproperty
  a_leave: assert property (p_leave) else $error("sup mode after resume");
  property p_start; flash_start_o |-> sup_mode_o && flash_fn_o inside {8'h00, 8'h01,
    8'h02, 8'h03, 8'h05, 8'h06, 8'h07}; endproperty
  a_start: assert property (p_start) else $error("bad routine start");
  property p_aux; flash_keep_aux_o; endproperty
  a_aux: assert property (p_aux) else $error("aux rows exposed");
  property p_fatal; s_fatal |=> halt_o; endproperty
  a_fatal: assert property (p_fatal) else $error("fatal code without halt");
  property p_addr; sram_rd_o || sram_wr_o |-> sram_addr_o >= SCD_PB_FIRST_GUARD_KEY; endproperty
  a_addr: assert property (p_addr) else $error("access outside block");
  property p_resume; resume_o |-> !halt_o ##1 !resume_o; endproperty
  a_resume: assert property (p_resume) else $error("bad resume pulse");
endmodule
bind scd_dispatch scd_monitor i_scd_monitor (.*);

/* verification/scd_partner.sv */
// Parameter block SRAM and flash routine engine.
// Assumes the dispatcher strobes.
`timescale 1ns/1ps
module scd_partner
  import scd_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rd_i, // Read
  input wire logic wr_i, // Write
  input wire logic [7:0] addr_i, // Address
  input wire logic [7:0] wdata_i, // Write data
  output logic [7:0] rdata_o, // Read data
  input wire logic start_i, // Start
  input wire logic [7:0] fn_i, // Function
  input wire logic slow_i, // Slow routine
  output logic done_o, // Done
  output logic has_rc_o // Return code left
);
  logic [7:0] mem [256];
  logic [3:0] cnt = 4'h0;
  initial rdata_o = 8'h00;
  // Unread data toggles, never holds
  always @(posedge clk_i) begin
    rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
    if (wr_i) mem[addr_i] <= wdata_i;
    done_o <= cnt == 4'h1;
    cnt <= start_i ? (slow_i ? 4'hA : 4'h2) : cnt - (cnt != 4'h0);
  end
  assign has_rc_o = !(fn_i inside {SCD_FN_TABLE, SCD_FN_CHECKSUM});
endmodule

/* verification/supervisory_call_dispatch_test.sv */
// Bench: core stimulus around the dispatcher.
// Assumes the partner model and bound checker.
`timescale 1ns/1ps
module supervisory_call_dispatch_test;
  import scd_pkg::*;
  logic clk_i = 0, rst_n_i = 0, op_valid_i = 0, serial_mode_i = 0, serial_req_i = 0;
  logic slow = 0, deny = 0, cal_ok = 1, sram_rd_o, sram_wr_o, flash_start_o, flash_done_i;
  logic flash_has_rc_i, busy_o, halt_o, resume_o, acc_clear_o;
  logic [7:0] opcode_i = 8'hFF, acc_i = 0, sp_i = 8'h40, serial_fn_i = 0;
  logic [7:0] sram_addr_o, sram_wdata_o, sram_rdata_i, flash_fn_o;
  logic [15:0] pc_i = 0, resume_pc_o;
  int miscompares = 0, compares = 0, cycles = 0;
  always #25 clk_i = ~clk_i;
  scd_dispatch i_scd_dispatch (.*, .flash_keep_aux_o(), .sup_mode_o(),
    .flash_denied_i(deny), .flash_fatal_i(1'h0), .cal_ok_i(cal_ok));
  scd_partner i_scd_partner (.clk_i, .rd_i(sram_rd_o), .wr_i(sram_wr_o),
    .addr_i(sram_addr_o), .wdata_i(sram_wdata_o), .rdata_o(sram_rdata_i),
    .start_i(flash_start_o), .fn_i(flash_fn_o), .slow_i(slow),
    .done_o(flash_done_i), .has_rc_o(flash_has_rc_i));
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic call(logic [7:0] fn, k1, k2, logic [15:0] pc, logic ser);
    int n = 0;
    while (busy_o !== 1'h0 && n++ < 80) @(negedge clk_i);
    i_scd_partner.mem[SCD_PB_FIRST_GUARD_KEY] = k1;
    i_scd_partner.mem[SCD_PB_SECOND_GUARD_KEY] = k2;
    @(posedge clk_i);
    op_valid_i <= !ser;
    serial_req_i <= ser;
    serial_fn_i <= fn;
    acc_i <= fn;
    opcode_i <= SCD_OP_CALL;
    pc_i <= pc;
    @(posedge clk_i);
    op_valid_i <= 1'h0;
    serial_req_i <= 1'h0;
    opcode_i <= 8'hFF;
    n = 0;
    while (resume_o !== 1'h1 && halt_o !== 1'h1 && n++ < 80) @(negedge clk_i);
    // Let the return code write land in the block
    @(negedge clk_i);
  endtask
  task automatic t_boot();
    logic seen = 0;
    for (int n = 0; n < 80 && resume_o !== 1'h1; n++) begin
      @(negedge clk_i);
      seen |= acc_clear_o === 1'h1;
    end
    chk("acc clear", seen, 1);
    chk("boot fn", flash_fn_o, SCD_FN_BOOT);
  endtask
  task automatic t_codes();
    logic [7:0] fns [6] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07};
    foreach (fns[i]) begin
      slow <= i[0];
      call(fns[i], 8'h3A, 8'h43, 16'h0100 + i, 0);
      chk("fn", flash_fn_o, fns[i]);
      chk("resume pc", resume_pc_o, 16'h0101 + i);
      chk("rc", i_scd_partner.mem[SCD_PB_FIRST_GUARD_KEY], i < 4 ? 8'h00 : 8'h3A);
    end
  endtask
  task automatic t_deny();
    deny <= 1'h1;
    call(SCD_FN_READ, 8'h3A, 8'h43, 16'h0200, 0);
    chk("denied rc", i_scd_partner.mem[SCD_PB_FIRST_GUARD_KEY], SCD_RC_PROTECT);
    deny <= 1'h0;
  endtask
  task automatic t_boot_keys();
    call(SCD_FN_BOOT, 8'h00, 8'h00, 16'h0300, 0);
    chk("boot halt", halt_o, 0);
    chk("boot pc", resume_pc_o, 16'h0301);
  endtask
  task automatic t_serial();
    serial_mode_i <= 1'h1;
    call(SCD_FN_ERASE_ALL, 8'h3A, 8'h43, 16'h0400, 1);
    chk("serial fn", flash_fn_o, SCD_FN_ERASE_ALL);
    serial_mode_i <= 1'h0;
  endtask
  task automatic t_badkey();
    call(SCD_FN_READ, 8'h3A, 8'h44, 16'h0500, 0);
    chk("key halt", halt_o, 1);
    chk("fatal rc", i_scd_partner.mem[SCD_PB_FIRST_GUARD_KEY], SCD_RC_FATAL);
    rst_n_i <= 1'h0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'h1;
    call(8'h04, 8'h3A, 8'h43, 16'h0600, 0);
    chk("undef halt", halt_o, 1);
  endtask
  task automatic t_calfail();
    i_scd_partner.mem[SCD_PB_FIRST_GUARD_KEY] = SCD_FIRST_GUARD_KEY_VALUE;
    cal_ok <= 1'h0;
    rst_n_i <= 1'h0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'h1;
    for (int n = 0; n < 80 && halt_o !== 1'h1; n++) @(negedge clk_i);
    chk("cal halt", halt_o, 1);
    chk("cal rc", i_scd_partner.mem[SCD_PB_FIRST_GUARD_KEY], SCD_RC_FATAL);
  endtask
  always @(posedge clk_i) begin
    if (++cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'h1;
    t_boot();
    t_codes();
    t_deny();
    t_boot_keys();
    t_serial();
    t_badkey();
    t_calfail();
    finish_test();
  end
endmodule
